// ==== crc16_step.sv ====
// CRC-16 byte step for the serial frame checksum
// Assumes one byte per call, reflected polynomial.
`timescale 1ns/1ps
module crc16_step (
  // Running value and byte
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data_in,
  // Updated value
  output logic      [15:0] crc_out
);
  // Eight shift steps per byte
  always_comb begin
    logic [15:0] c;
    c = crc_in ^ {8'h00, data_in};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ map_pkg::CRC_POLY) : (c >> 1);
    end
    crc_out = c;
  end
endmodule : crc16_step

// ==== map_pkg.sv ====
// Constants for the sensor's frame handling and register map
// Assumes one 250 MHz clock and byte-wide frame streams from a UART.
// Function
// - Answer only frames for node 45
// - FLOAT32 low mantissa word first, sign word second
// - Unassigned map slots read back as all ones
// - Function 0x10 writes map config, echoed reply
// - Function 0x03 reads window via configuration order
// - Serious error forces NaN, no sensor, fault
// - Expose diagnostic groups 7.x, 19.x, 21.x
// - Config 6001..6010, window 3001..3020
// - Status register 602 holds error flags
// - Critical error gives NaN or 0x8000
// - Status bits 0,1,2,9,11 as assigned
package map_pkg;
  localparam logic [7:0]  NODE_ADDR     = 8'h2d;
  localparam logic [7:0]  FN_READ_HOLD  = 8'h03;
  localparam logic [7:0]  FN_READ_INP   = 8'h04;
  localparam logic [7:0]  FN_WRITE_MULT = 8'h10;
  localparam logic [15:0] CFG_BASE      = 16'h1770;
  localparam logic [15:0] WIN_BASE      = 16'h0bb8;
  localparam logic [15:0] STATUS_ADDR   = 16'h0259;
  localparam logic [15:0] TEMP_ADDR     = 16'h03ea;
  localparam int          CFG_SLOTS     = 10;
  localparam int          WIN_REGS      = 20;
  localparam logic [15:0] CFG_RESET     = 16'hffff;
  localparam logic [15:0] UNMAPPED      = 16'hffff;
  localparam logic [15:0] INT16_ERR     = 16'h8000;
  localparam logic [31:0] FLOAT_NAN     = 32'h7fc00000;
  localparam logic [15:0] CRC_INIT      = 16'hffff;
  localparam logic [15:0] CRC_POLY      = 16'ha001;
  localparam int          BIT_LOW       = 0;
  localparam int          BIT_HIGH      = 1;
  localparam int          BIT_INF       = 2;
  localparam int          BIT_UNREACH   = 9;
  localparam int          BIT_DISPLAY   = 11;
  localparam int          RX_MAX        = 29;
  localparam int          TX_MAX        = 45;
endpackage : map_pkg

// ==== modbus_custom_map_slave.sv ====
// Frame-level slave: register window, custom map, status and error substitution
// Assumes bytes arrive with rx_valid and frame end marked by rx_end (gap detect outside).
`timescale 1ns/1ps
module modbus_custom_map_slave (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // Received bytes
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_end,
  // Transmitted bytes
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic      [7:0]  tx_data,
  output logic             tx_last,
  // Measurements and conditions
  input  wire logic [31:0] temp_c_float,
  input  wire logic [31:0] temp_f_float,
  input  wire logic [31:0] temp_k_float,
  input  wire logic [15:0] temp_int16,
  input  wire logic [15:0] error_flags_in,
  input  wire logic        critical_error,
  // Object properties toward the building-bus side
  output logic      [31:0] bn_present_value,
  output logic             bn_reliability_no_sensor,
  output logic             bn_event_fault,
  output logic             diag_temp_bad,
  output logic             diag_unreachable,
  output logic             diag_display
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_s1_ff, rst_ff;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_ff <= 1'b0;
      rst_ff    <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_ff    <= rst_s1_ff;
    end
  end
  wire rst_n = rst_ff;

  typedef enum logic [3:0] {
    S_RX = 4'b0001, S_EVAL = 4'b0010, S_TX = 4'b0100, S_DROP = 4'b1000
  } state_t;

  state_t      state_ff;
  logic [7:0]  rx_buf_ff [map_pkg::RX_MAX];
  logic [4:0]  rx_cnt_ff;
  logic [15:0] crc_ff;
  logic [15:0] cfg_ff [map_pkg::CFG_SLOTS];
  logic [7:0]  tx_buf_ff [map_pkg::TX_MAX];
  logic [5:0]  tx_len_ff, tx_idx_ff;
  logic [15:0] crc_next;
  logic [15:0] tx_crc_step;

  crc16_step u_crc (
    .crc_in  (crc_ff),
    .data_in (rx_data),
    .crc_out (crc_next)
  );

  // ----------------------------------------------------------------
  // Status and substitution
  // ----------------------------------------------------------------
  logic [15:0] status_word;
  assign status_word = {4'h0, error_flags_in[map_pkg::BIT_DISPLAY], 1'b0,
                        error_flags_in[map_pkg::BIT_UNREACH], 6'h00,
                        error_flags_in[2:0]};
  assign diag_temp_bad    = |status_word[2:0];
  assign diag_unreachable = status_word[map_pkg::BIT_UNREACH];
  assign diag_display     = status_word[map_pkg::BIT_DISPLAY];

  // Building-bus object state under a serious error
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bn_present_value         <= 32'h00000000;
      bn_reliability_no_sensor <= 1'b0;
      bn_event_fault           <= 1'b0;
    end else begin
      bn_present_value         <= critical_error ? map_pkg::FLOAT_NAN : temp_c_float;
      bn_reliability_no_sensor <= critical_error;
      bn_event_fault           <= critical_error;
    end
  end

  // Source value of a 32-bit word at an even register address
  function automatic logic [31:0] float_at(input logic [15:0] a);
    logic [31:0] v;
    case (a)
      map_pkg::TEMP_ADDR:         v = temp_c_float;
      map_pkg::TEMP_ADDR + 16'h2: v = temp_f_float;
      map_pkg::TEMP_ADDR + 16'h6: v = temp_k_float;
      default:                    v = {map_pkg::UNMAPPED, map_pkg::UNMAPPED};
    endcase
    return critical_error && (v != 32'hffffffff) ? map_pkg::FLOAT_NAN : v;
  endfunction : float_at

  // One 16-bit register; low mantissa word at the base address
  function automatic logic [15:0] reg_at(input logic [15:0] a);
    logic [31:0] f;
    logic [15:0] r;
    f = float_at({a[15:1], 1'b0});
    r = a[0] ? f[31:16] : f[15:0];
    if (a == map_pkg::STATUS_ADDR)
      r = status_word;
    else if (a == map_pkg::TEMP_ADDR + 16'h10)
      r = critical_error ? map_pkg::INT16_ERR : temp_int16;
    return r;
  endfunction : reg_at

  // Window register: pairs by slot, unassigned slots all ones
  function automatic logic [15:0] win_at(input logic [15:0] a);
    logic [15:0] off;
    logic [15:0] src;
    off = a - map_pkg::WIN_BASE;
    src = cfg_ff[off[4:1]];
    if (src == map_pkg::CFG_RESET)
      return map_pkg::UNMAPPED;
    return reg_at(src + {15'h0, off[0]});
  endfunction : win_at

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  wire [7:0]  req_fn    = rx_buf_ff[1];
  wire [15:0] req_start = {rx_buf_ff[2], rx_buf_ff[3]};
  wire [15:0] req_qty   = {rx_buf_ff[4], rx_buf_ff[5]};
  // Request end, one bit wider so a high start address cannot wrap into range
  wire [16:0] req_end   = {1'b0, req_start} + {1'b0, req_qty};
  wire        crc_good  = (crc_ff == 16'h0000) && (rx_cnt_ff >= 5'd4);
  wire        for_me    = rx_buf_ff[0] == map_pkg::NODE_ADDR;
  wire        is_read   = (req_fn == map_pkg::FN_READ_HOLD) || (req_fn == map_pkg::FN_READ_INP);
  wire        win_hit   = (req_start >= map_pkg::WIN_BASE) && (req_qty != 16'h0) &&
                          (req_end <= 17'(map_pkg::WIN_BASE) + 17'(map_pkg::WIN_REGS));
  wire        rd_ok     = is_read && (req_qty != 16'h0) && (req_qty <= 16'd20);
  wire        wr_ok     = (req_fn == map_pkg::FN_WRITE_MULT) &&
                          (req_start >= map_pkg::CFG_BASE) && (req_qty != 16'h0) &&
                          (req_end <= 17'(map_pkg::CFG_BASE) + 17'(map_pkg::CFG_SLOTS)) &&
                          (rx_buf_ff[6] == 8'(req_qty << 1));

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff  <= S_RX;
      rx_cnt_ff <= 5'd0;
      crc_ff    <= map_pkg::CRC_INIT;
      tx_len_ff <= 6'd0;
      tx_idx_ff <= 6'd0;
      for (int i = 0; i < map_pkg::CFG_SLOTS; i++) cfg_ff[i] <= map_pkg::CFG_RESET;
      for (int i = 0; i < map_pkg::RX_MAX; i++) rx_buf_ff[i] <= 8'h00;
      for (int i = 0; i < map_pkg::TX_MAX; i++) tx_buf_ff[i] <= 8'h00;
    end else begin
      case (state_ff)
        S_RX: begin
          if (rx_valid) begin
            if (rx_cnt_ff < 5'(map_pkg::RX_MAX)) begin
              rx_buf_ff[rx_cnt_ff] <= rx_data;
              rx_cnt_ff            <= rx_cnt_ff + 5'd1;
              crc_ff               <= crc_next;
            end else begin
              state_ff <= S_DROP;
            end
          end else if (rx_end) begin
            state_ff <= S_EVAL;
          end
        end
        S_EVAL: begin
          state_ff  <= S_RX;
          rx_cnt_ff <= 5'd0;
          crc_ff    <= map_pkg::CRC_INIT;
          if (crc_good && for_me) begin
            tx_buf_ff[0] <= map_pkg::NODE_ADDR;
            tx_buf_ff[1] <= req_fn;
            tx_idx_ff    <= 6'd0;
            if (rd_ok) begin
              tx_buf_ff[2] <= 8'(req_qty << 1);
              for (int i = 0; i < map_pkg::WIN_REGS; i++) begin
                logic [15:0] a, v;
                a = req_start + 16'(i);
                v = win_hit ? win_at(a) : reg_at(a);
                tx_buf_ff[3 + 2 * i] <= v[15:8];
                tx_buf_ff[4 + 2 * i] <= v[7:0];
              end
              tx_len_ff <= 6'(3 + 2 * req_qty);
              state_ff  <= S_TX;
            end else if (wr_ok) begin
              for (int i = 0; i < map_pkg::CFG_SLOTS; i++)
                if (i < int'(req_qty))
                  cfg_ff[4'(req_start - map_pkg::CFG_BASE) + 4'(i)] <=
                    {rx_buf_ff[7 + 2 * i], rx_buf_ff[8 + 2 * i]};
              tx_buf_ff[2] <= rx_buf_ff[2];
              tx_buf_ff[3] <= rx_buf_ff[3];
              tx_buf_ff[4] <= rx_buf_ff[4];
              tx_buf_ff[5] <= rx_buf_ff[5];
              tx_len_ff    <= 6'd6;
              state_ff     <= S_TX;
            end
          end
        end
        S_TX: begin
          if (tx_ready) begin
            if (tx_idx_ff == tx_len_ff + 6'd1) state_ff <= S_RX;
            tx_idx_ff <= tx_idx_ff + 6'd1;
            if (tx_idx_ff < tx_len_ff) crc_ff <= tx_crc_step;
            else crc_ff <= crc_ff;
          end
          if (tx_ready && tx_idx_ff == tx_len_ff + 6'd1) crc_ff <= map_pkg::CRC_INIT;
        end
        S_DROP: begin
          if (rx_end) begin
            state_ff  <= S_RX;
            rx_cnt_ff <= 5'd0;
            crc_ff    <= map_pkg::CRC_INIT;
          end
        end
        default: state_ff <= S_RX;
      endcase
    end
  end

  // Outgoing checksum runs over payload bytes, then sent low byte first
  crc16_step u_crc_tx (
    .crc_in  (crc_ff),
    .data_in (tx_buf_ff[tx_idx_ff]),
    .crc_out (tx_crc_step)
  );
  assign tx_valid = state_ff == S_TX;
  assign tx_data  = (tx_idx_ff < tx_len_ff) ? tx_buf_ff[tx_idx_ff] :
                    (tx_idx_ff == tx_len_ff) ? crc_ff[7:0] : crc_ff[15:8];
  assign tx_last  = tx_valid && (tx_idx_ff == tx_len_ff + 6'd1);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_bn_fault_follow: assert property (@(posedge mclk) disable iff (!rst_n)
    critical_error |=> bn_event_fault && bn_reliability_no_sensor)
    else $error("Fault properties not set after serious error");
  a_status_bits: assert property (@(posedge mclk) disable iff (!rst_n)
    status_word[8:3] == 6'h00 && status_word[15:12] == 4'h0)
    else $error("Reserved status bits set");
  a_reply_addr: assert property (@(posedge mclk) disable iff (!rst_n)
    (tx_valid && tx_idx_ff == 6'd0) |-> tx_data == map_pkg::NODE_ADDR)
    else $error("Reply carries wrong node address");
  a_eval_one: assert property (@(posedge mclk) disable iff (!rst_n)
    state_ff == S_EVAL |=> state_ff != S_EVAL)
    else $error("Evaluation lasted more than one cycle");
  a_bytecount: assert property (@(posedge mclk) disable iff (!rst_n)
    (tx_valid && tx_idx_ff == 6'd2 && is_read) |-> tx_len_ff == 6'(3) + 6'(tx_data))
    else $error("Byte count disagrees with reply length");
  a_diag_map: assert property (@(posedge mclk) disable iff (!rst_n)
    diag_unreachable == error_flags_in[9] && diag_display == error_flags_in[11])
    else $error("Diagnostic groups disagree with status");
  a_nan_value: assert property (@(posedge mclk) disable iff (!rst_n)
    critical_error |=> bn_present_value == map_pkg::FLOAT_NAN)
    else $error("Value not replaced by NaN");
  a_tx_end: assert property (@(posedge mclk) disable iff (!rst_n)
    (tx_last && tx_ready) |=> state_ff == S_RX)
    else $error("Reply did not end after checksum");
endmodule : modbus_custom_map_slave

// ==== rtu_master.sv ====
// Master-side model: sends request frames and collects the slave's reply
// Assumes one clock; drives on the falling edge, a reply byte is taken on the falling edge too.
`timescale 1ns/1ps
module rtu_master (
  // Clock
  input  wire logic       mclk,
  // Request bytes toward the slave
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            rx_end,
  // Reply bytes from the slave
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready
);
  logic slow = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h5a;
    rx_end   = 1'b0;
    tx_ready = 1'b0;
  end

  // Frame checksum, reflected polynomial
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction : crc16

  // Send a request with checksum low byte first, then the frame gap
  task automatic send(input logic [7:0] req[$], input logic bad_crc);
    logic [15:0] c;
    c = crc16(req);
    req.push_back(c[7:0]);
    req.push_back(c[15:8] ^ {7'h00, bad_crc});
    foreach (req[i]) begin
      @(negedge mclk);
      rx_valid <= 1'b1;
      rx_data  <= req[i];
    end
    @(negedge mclk);
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
    rx_end   <= 1'b1;
    @(negedge mclk);
    rx_end   <= 1'b0;
  endtask : send

  // Collect reply bytes; slow mode stalls every other cycle
  task automatic collect(output logic [7:0] rsp[$]);
    int   n;
    logic done;
    rsp  = {};
    n    = 0;
    done = 1'b0;
    while (!done && n < 200) begin
      @(negedge mclk);
      n++;
      if (tx_valid === 1'b1 && !(slow && n[0])) begin
        tx_ready <= 1'b1;
        rsp.push_back(tx_data);
        done = tx_last;
      end else begin
        tx_ready <= 1'b0;
      end
    end
    @(negedge mclk);
    tx_ready <= 1'b0;
  endtask : collect
endmodule : rtu_master

// ==== testbench.sv ====
// Self-checking bench for the custom map slave: reads, map writes, status, faults
// Assumes the design files and rtu_master.sv are compiled first.
`timescale 1ns/1ps
module testbench;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        mclk    = 1'b0;
  logic        reset_n = 1'b0;
  logic        rx_valid, rx_end, tx_valid, tx_ready, tx_last;
  logic [7:0]  rx_data, tx_data;
  logic [31:0] temp_c  = 32'h41bb851f;
  logic [31:0] temp_f  = 32'h42743ae1;
  logic [31:0] temp_k  = 32'h43967852;
  logic [15:0] temp_i  = 16'h00ea;
  logic [15:0] flags   = 16'h0000;
  logic        crit    = 1'b0;
  logic [31:0] bn_pv;
  logic        bn_rel, bn_flt, d_temp, d_unr, d_disp;
  logic [7:0]  rsp[$];
  logic [7:0]  none[$];
  int          error_cnt       = 0;
  int          samples_checked = 0;

  // Clock
  always #2 mclk = ~mclk;

  modbus_custom_map_slave i_dut (
    .mclk(mclk), .reset_n(reset_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_end(rx_end), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_last(tx_last), .temp_c_float(temp_c), .temp_f_float(temp_f),
    .temp_k_float(temp_k), .temp_int16(temp_i), .error_flags_in(flags),
    .critical_error(crit), .bn_present_value(bn_pv), .bn_reliability_no_sensor(bn_rel),
    .bn_event_fault(bn_flt), .diag_temp_bad(d_temp), .diag_unreachable(d_unr),
    .diag_display(d_disp)
  );

  rtu_master i_master (
    .mclk(mclk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : cmp_val

  // Whole reply against expected bytes plus checksum
  task automatic cmp_frame(input string what, input logic [7:0] exp[$]);
    logic [15:0] c;
    c = i_master.crc16(exp);
    if (exp.size() > 0) exp = {exp, c[7:0], c[15:8]};
    cmp_val({what, " length"}, exp.size(), rsp.size());
    foreach (exp[i]) cmp_val(what, exp[i], (i < rsp.size()) ? rsp[i] : 8'hxx);
  endtask : cmp_frame

  task automatic xfer(input logic [7:0] req[$], input logic bad);
    i_master.send(req, bad);
    i_master.collect(rsp);
  endtask : xfer

  task automatic rd(input logic [7:0] fn, input logic [15:0] a, input logic [7:0] qty);
    xfer({8'h2d, fn, a[15:8], a[7:0], 8'h00, qty}, 1'b0);
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic [7:0] qty, input logic [7:0] d[$]);
    xfer({8'h2d, 8'h10, a[15:8], a[7:0], 8'h00, qty, qty << 1, d}, 1'b0);
  endtask : wr

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_map();
    rd(8'h03, 16'h0bb8, 8'h02);
    cmp_frame("unassigned", {8'h2d, 8'h03, 8'h04, 8'hff, 8'hff, 8'hff, 8'hff});
    wr(16'h1770, 8'h02, {8'h03, 8'hec, 8'h03, 8'hea});
    cmp_frame("map echo", {8'h2d, 8'h10, 8'h17, 8'h70, 8'h00, 8'h02});
    i_master.slow = 1'b1;
    rd(8'h03, 16'h0bb8, 8'h06);
    i_master.slow = 1'b0;
    cmp_frame("mapped", {8'h2d, 8'h03, 8'h0c, temp_f[15:8], temp_f[7:0], temp_f[31:24],
      temp_f[23:16], temp_c[15:8], temp_c[7:0], temp_c[31:24], temp_c[23:16],
      8'hff, 8'hff, 8'hff, 8'hff});
    cmp_val("present value", temp_c, bn_pv);
    wr(16'h1779, 8'h01, {8'h03, 8'hfa});
    cmp_frame("last slot echo", {8'h2d, 8'h10, 8'h17, 8'h79, 8'h00, 8'h01});
    rd(8'h04, 16'h0bca, 8'h01);
    cmp_frame("last window", {8'h2d, 8'h04, 8'h02, temp_i[15:8], temp_i[7:0]});
    $display("test map done");
  endtask : t_map

  task automatic t_refuse();
    wr(16'h177a, 8'h01, {8'h03, 8'hea});
    cmp_frame("outside config", none);
    xfer({8'h2e, 8'h03, 8'h0b, 8'hb8, 8'h00, 8'h01}, 1'b0);
    cmp_frame("other node", none);
    xfer({8'h2d, 8'h03, 8'h0b, 8'hb8, 8'h00, 8'h01}, 1'b1);
    cmp_frame("bad checksum", none);
    rd(8'h03, 16'h0bb8, 8'h15);
    cmp_frame("too long read", none);
    $display("test refuse done");
  endtask : t_refuse

  task automatic t_status();
    int bits[5] = '{0, 1, 2, 9, 11};
    foreach (bits[i]) begin
      @(negedge mclk);
      flags = 16'h0001 << bits[i];
      rd(8'h04, 16'h0259, 8'h01);
      cmp_frame("status", {8'h2d, 8'h04, 8'h02, flags[15:8], flags[7:0]});
      cmp_val("temp diag", bits[i] < 3, d_temp);
      cmp_val("unreachable diag", bits[i] == 9, d_unr);
      cmp_val("display diag", bits[i] == 11, d_disp);
    end
    // Unassigned flag inputs must not reach the status word
    @(negedge mclk);
    flags = 16'hffff;
    rd(8'h04, 16'h0259, 8'h01);
    cmp_frame("status reserved", {8'h2d, 8'h04, 8'h02, 8'h0a, 8'h07});
    flags = 16'h0000;
    $display("test status done");
  endtask : t_status

  task automatic t_fault();
    @(negedge mclk);
    crit = 1'b1;
    repeat (2) @(negedge mclk);
    cmp_val("present value", 32'h7fc00000, bn_pv);
    cmp_val("reliability", 1'b1, bn_rel);
    cmp_val("event state", 1'b1, bn_flt);
    rd(8'h03, 16'h0bb8, 8'h06);
    cmp_frame("fault read", {8'h2d, 8'h03, 8'h0c, 8'h00, 8'h00, 8'h7f, 8'hc0, 8'h00, 8'h00,
      8'h7f, 8'hc0, 8'hff, 8'hff, 8'hff, 8'hff});
    rd(8'h04, 16'h0bca, 8'h01);
    cmp_frame("fault int", {8'h2d, 8'h04, 8'h02, 8'h80, 8'h00});
    crit = 1'b0;
    repeat (2) @(negedge mclk);
    cmp_val("reliability", 1'b0, bn_rel);
    wr(16'h1772, 8'h01, {8'h03, 8'hf0});
    cmp_frame("third slot echo", {8'h2d, 8'h10, 8'h17, 8'h72, 8'h00, 8'h01});
    rd(8'h03, 16'h0bbc, 8'h02);
    cmp_frame("kelvin", {8'h2d, 8'h03, 8'h04, temp_k[15:8], temp_k[7:0], temp_k[31:24],
      temp_k[23:16]});
    $display("test fault done");
  endtask : t_fault

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    repeat (20) @(negedge mclk);
    reset_n = 1'b1;
    repeat (4) @(negedge mclk);
    t_map();
    t_refuse();
    t_status();
    t_fault();
    end_of_test();
  end

  // Watchdog, well beyond about 20 frames of at most 250 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    end_of_test();
  end
endmodule : testbench
